// ===== rtl/pbist_core.sv
// The strobed register port was decided locally.
`timescale 1ns/100ps
module pbist_core #(
	parameter int PKT_LEN_LONG = 1518,
	parameter int PKT_LEN_SHORT = 64,
	parameter int IPG_BYTES = 125,
	parameter int LOCK_MATCHES = 4,
	parameter int LOSS_ERRORS = 4
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [pbist_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [pbist_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic tx_byte_en_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	input wire logic core_normal_power_in,
	output logic [pbist_pkg::DATA_W-1:0] reg_rdata_out,
	output logic [7:0] tx_data_out,
	output logic tx_valid_out,
	output logic [pbist_pkg::LB_W-1:0] loopback_sel_out,
	output logic irq_out
);

	typedef struct packed {
		logic [pbist_pkg::DATA_W-1:0] ctrl;
		logic [pbist_pkg::DATA_W-1:0] rdata;
		pbist_pkg::pbist_gen_t gen_st;
		logic [pbist_pkg::LEN_W-1:0] len_cnt;
		logic [pbist_pkg::LEN_W-1:0] gap_cnt;
		logic [pbist_pkg::LFSR_W-1:0] gen_lfsr;
		logic [7:0] tx_data;
		logic tx_valid;
		logic [pbist_pkg::LFSR_W-1:0] chk_lfsr;
		logic [7:0] match_cnt;
		logic [7:0] miss_cnt;
		logic locked;
		logic sync_loss;
		logic power_ok;
		logic [pbist_pkg::BCNT_W-1:0] bcnt;
		logic [pbist_pkg::ECNT_W-1:0] ecnt;
		logic [pbist_pkg::BCNT_W-1:0] bcnt_snap;
		logic [pbist_pkg::ECNT_W-1:0] ecnt_snap;
		logic frozen;
		logic [pbist_pkg::IRQ_W-1:0] irq_stat;
		logic [pbist_pkg::IRQ_W-1:0] irq_mask;
		logic irq;
	} pbist_state_t;

	localparam logic [pbist_pkg::LEN_W-1:0] LEN_LONG = pbist_pkg::LEN_W'(PKT_LEN_LONG);
	localparam logic [pbist_pkg::LEN_W-1:0] LEN_SHORT = pbist_pkg::LEN_W'(PKT_LEN_SHORT);
	localparam logic [pbist_pkg::LEN_W-1:0] GAP_LEN = pbist_pkg::LEN_W'(IPG_BYTES);
	localparam logic [7:0] LOCK_N = 8'(LOCK_MATCHES);
	localparam logic [7:0] LOSS_N = 8'(LOSS_ERRORS);
	localparam logic [pbist_pkg::BCNT_W-1:0] BCNT_MAX = '1;
	localparam logic [pbist_pkg::ECNT_W-1:0] ECNT_MAX = '1;
	// Writable control bits: modes, enable and loopback; reserved bits read as zero
	localparam logic [pbist_pkg::DATA_W-1:0] CTRL_WMASK = 16'hf01f;

	pbist_state_t q_r;
	pbist_state_t q_nxt;

	// Advance the x^15+x^14+1 sequence by one byte; the low byte is the new data.
	// Generator and checker share it so both ends agree on bit order.
	function automatic logic [pbist_pkg::LFSR_W-1:0] pbist_step8(
		input logic [pbist_pkg::LFSR_W-1:0] s
	);
		logic [pbist_pkg::LFSR_W-1:0] v;
		v = s;
		for (int i = 0; i < 8; i++) begin
			v = {v[pbist_pkg::LFSR_W-2:0], v[pbist_pkg::LFSR_W-1] ^ v[pbist_pkg::LFSR_W-2]};
		end
		return v;
	endfunction : pbist_step8

	logic cnt_mode;
	logic prbs_sel;
	logic gen_en;
	logic [pbist_pkg::LEN_W-1:0] pkt_len;
	logic [pbist_pkg::LFSR_W-1:0] gen_next;
	logic [pbist_pkg::LFSR_W-1:0] chk_next;
	logic chk_active;
	logic halted;
	logic wr_ctrl;
	logic wr_ecnt;
	logic wr_irq;
	logic rd_status;

	// Decoded controls and strobes
	assign cnt_mode = q_r.ctrl[pbist_pkg::CTRL_CNT_MODE];
	assign prbs_sel = q_r.ctrl[pbist_pkg::CTRL_PRBS_SEL];
	assign gen_en = q_r.ctrl[pbist_pkg::CTRL_GEN_EN];
	assign pkt_len = q_r.ctrl[pbist_pkg::CTRL_SHORT_PKT] ? LEN_SHORT : LEN_LONG;
	assign gen_next = pbist_step8(q_r.gen_lfsr);
	assign chk_next = pbist_step8(q_r.chk_lfsr);
	assign chk_active = prbs_sel;
	assign halted = !cnt_mode && (q_r.bcnt == BCNT_MAX || q_r.ecnt == ECNT_MAX);
	assign wr_ctrl = reg_wr_in && reg_addr_in == pbist_pkg::OFF_CTRL;
	assign wr_ecnt = reg_wr_in && reg_addr_in == pbist_pkg::OFF_ERR_CNT;
	assign wr_irq = reg_wr_in && reg_addr_in == pbist_pkg::OFF_IRQ_STAT;
	assign rd_status = reg_rd_in && reg_addr_in == pbist_pkg::OFF_STATUS;

	// Next-state logic for the whole block
	always_comb begin
		logic [pbist_pkg::IRQ_W-1:0] ev;
		logic mismatch;
		ev = '0;
		mismatch = 1'b0;
		q_nxt = q_r;
		q_nxt.tx_valid = 1'b0;
		q_nxt.rdata = '0;
		q_nxt.power_ok = core_normal_power_in;

		// Control register; reserved bits stay zero
		if (wr_ctrl) begin
			q_nxt.ctrl = reg_wdata_in & CTRL_WMASK;
		end
		if (reg_wr_in && reg_addr_in == pbist_pkg::OFF_IRQ_MASK) begin
			q_nxt.irq_mask = reg_wdata_in[pbist_pkg::IRQ_W-1:0];
		end

		// Packet generator, one byte per slot strobe
		case (q_r.gen_st)
			pbist_pkg::GEN_IDLE: begin
				if (gen_en) begin
					q_nxt.gen_st = pbist_pkg::GEN_SEND;
					q_nxt.len_cnt = '0;
					q_nxt.gen_lfsr = pbist_pkg::LFSR_SEED;
				end
			end
			pbist_pkg::GEN_SEND: begin
				if (!gen_en) begin
					q_nxt.gen_st = pbist_pkg::GEN_IDLE;
				end else if (tx_byte_en_in) begin
					q_nxt.tx_valid = 1'b1;
					if (prbs_sel) begin
						q_nxt.tx_data = gen_next[7:0];
						q_nxt.gen_lfsr = gen_next;
					end else begin
						q_nxt.tx_data = pbist_pkg::CONST_BYTE;
					end
					q_nxt.len_cnt = q_r.len_cnt + 16'h0001;
					if (q_r.len_cnt == pkt_len - 16'h0001) begin
						q_nxt.gap_cnt = '0;
						// Constant mode stops after a single packet
						q_nxt.gen_st = prbs_sel ? pbist_pkg::GEN_GAP : pbist_pkg::GEN_DONE;
						ev[pbist_pkg::IRQ_GEN_DONE] = !prbs_sel;
					end
				end
			end
			pbist_pkg::GEN_GAP: begin
				if (!gen_en) begin
					q_nxt.gen_st = pbist_pkg::GEN_IDLE;
				end else if (tx_byte_en_in) begin
					q_nxt.gap_cnt = q_r.gap_cnt + 16'h0001;
					if (q_r.gap_cnt == GAP_LEN - 16'h0001) begin
						q_nxt.len_cnt = '0;
						q_nxt.gen_st = pbist_pkg::GEN_SEND;
					end
				end
			end
			pbist_pkg::GEN_DONE: begin
				// Holds until software clears the enable, so only one packet goes out
				if (!gen_en) begin
					q_nxt.gen_st = pbist_pkg::GEN_IDLE;
				end
			end
			default: begin
				q_nxt.gen_st = pbist_pkg::GEN_IDLE;
			end
		endcase

		// Checker: reseed from the stream until enough bytes match, then track it
		if (!chk_active) begin
			q_nxt.locked = 1'b0;
			q_nxt.match_cnt = '0;
			q_nxt.miss_cnt = '0;
		end else if (rx_valid_in) begin
			mismatch = rx_data_in != chk_next[7:0];
			if (!q_r.locked) begin
				q_nxt.chk_lfsr = {q_r.chk_lfsr[pbist_pkg::LFSR_W-9:0], rx_data_in};
				q_nxt.match_cnt = mismatch ? 8'h00 : q_r.match_cnt + 8'h01;
				if (!mismatch && q_r.match_cnt == LOCK_N - 8'h01) begin
					q_nxt.locked = 1'b1;
					q_nxt.miss_cnt = '0;
				end
			end else begin
				q_nxt.chk_lfsr = chk_next;
				q_nxt.miss_cnt = mismatch ? q_r.miss_cnt + 8'h01 : 8'h00;
				if (mismatch && q_r.miss_cnt == LOSS_N - 8'h01) begin
					q_nxt.locked = 1'b0;
					q_nxt.match_cnt = '0;
					ev[pbist_pkg::IRQ_SYNC_LOSS] = 1'b1;
				end
			end
		end

		// Byte and error counters; halted in single mode at any maximum
		if (chk_active && rx_valid_in && !halted) begin
			q_nxt.bcnt = q_r.bcnt + 16'h0001;
			if (q_r.bcnt == BCNT_MAX) begin
				ev[pbist_pkg::IRQ_CNT_WRAP] = 1'b1;
			end
			if (q_r.locked && mismatch) begin
				q_nxt.ecnt = q_r.ecnt + 8'h01;
				if (q_r.ecnt == ECNT_MAX) begin
					ev[pbist_pkg::IRQ_CNT_WRAP] = 1'b1;
				end
			end
		end

		// Lock and lock-and-clear; a write with neither bit releases the freeze
		if (wr_ecnt) begin
			if (reg_wdata_in[pbist_pkg::ECNT_LOCK] || reg_wdata_in[pbist_pkg::ECNT_LOCK_CLR]) begin
				q_nxt.frozen = 1'b1;
				q_nxt.bcnt_snap = q_r.bcnt;
				q_nxt.ecnt_snap = q_r.ecnt;
			end else begin
				q_nxt.frozen = 1'b0;
			end
			if (reg_wdata_in[pbist_pkg::ECNT_LOCK_CLR]) begin
				q_nxt.bcnt = '0;
				q_nxt.ecnt = '0;
			end
		end

		// Sync loss latches; a read clears it, but a new loss in that cycle wins
		if (rd_status) begin
			q_nxt.sync_loss = 1'b0;
		end
		if (ev[pbist_pkg::IRQ_SYNC_LOSS]) begin
			q_nxt.sync_loss = 1'b1;
		end

		// Sticky interrupt bits, write one to clear, set beats clear
		q_nxt.irq_stat = (q_r.irq_stat & ~(wr_irq ? reg_wdata_in[pbist_pkg::IRQ_W-1:0] : 3'h0))
			| ev;
		q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);

		// Read data appears the cycle after the strobe; unmapped reads give zero
		if (reg_rd_in) begin
			case (reg_addr_in)
				pbist_pkg::OFF_CTRL: q_nxt.rdata = q_r.ctrl;
				pbist_pkg::OFF_STATUS: begin
					q_nxt.rdata[pbist_pkg::STAT_LOCKED] = q_r.locked;
					q_nxt.rdata[pbist_pkg::STAT_SYNC_LOSS] = q_r.sync_loss;
					q_nxt.rdata[pbist_pkg::STAT_GEN_BUSY] = q_r.gen_st == pbist_pkg::GEN_SEND
						|| q_r.gen_st == pbist_pkg::GEN_GAP;
					q_nxt.rdata[pbist_pkg::STAT_POWER_OK] = q_r.power_ok;
				end
				pbist_pkg::OFF_BYTE_CNT: q_nxt.rdata = q_r.frozen ? q_r.bcnt_snap : q_r.bcnt;
				pbist_pkg::OFF_ERR_CNT: q_nxt.rdata = {8'h00, q_r.frozen ? q_r.ecnt_snap : q_r.ecnt};
				pbist_pkg::OFF_IRQ_STAT: q_nxt.rdata = {13'h0000, q_r.irq_stat};
				pbist_pkg::OFF_IRQ_MASK: q_nxt.rdata = {13'h0000, q_r.irq_mask};
				default: q_nxt.rdata = '0;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			q_r <= '0;
			q_r.ctrl <= pbist_pkg::REG_RESET;
			q_r.gen_st <= pbist_pkg::GEN_IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata_out = q_r.rdata;
	assign tx_data_out = q_r.tx_data;
	assign tx_valid_out = q_r.tx_valid;
	assign loopback_sel_out = q_r.ctrl[pbist_pkg::CTRL_LB_HI:0];
	assign irq_out = q_r.irq;

endmodule : pbist_core

// ===== rtl/pbist_pkg.sv
package pbist_pkg;
	// Register offsets on the management port
	localparam logic [7:0] OFF_CTRL = 8'h16;
	localparam logic [7:0] OFF_STATUS = 8'h17;
	localparam logic [7:0] OFF_BYTE_CNT = 8'h71;
	localparam logic [7:0] OFF_ERR_CNT = 8'h72;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h73;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h74;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Control register fields
	localparam int CTRL_CNT_MODE = 15;
	localparam int CTRL_PRBS_SEL = 14;
	localparam int CTRL_SHORT_PKT = 13;
	localparam int CTRL_GEN_EN = 12;
	localparam int CTRL_LB_HI = 4;
	localparam int LB_W = 5;

	// Loopback point codes
	localparam logic [4:0] LB_NONE = 5'h00;
	localparam logic [4:0] LB_MAC_IF = 5'h01;
	localparam logic [4:0] LB_CODING = 5'h02;
	localparam logic [4:0] LB_DIGITAL = 5'h04;
	localparam logic [4:0] LB_ANALOG = 5'h08;
	localparam logic [4:0] LB_FAR_END = 5'h10;

	// Status register fields
	localparam int STAT_LOCKED = 11;
	localparam int STAT_SYNC_LOSS = 10;
	localparam int STAT_GEN_BUSY = 9;
	localparam int STAT_POWER_OK = 8;

	// Error-count register write bits
	localparam int ECNT_LOCK = 0;
	localparam int ECNT_LOCK_CLR = 1;

	// Interrupt status and mask fields
	localparam int IRQ_W = 3;
	localparam int IRQ_SYNC_LOSS = 0;
	localparam int IRQ_CNT_WRAP = 1;
	localparam int IRQ_GEN_DONE = 2;

	// Counter widths and sequence
	localparam int BCNT_W = 16;
	localparam int ECNT_W = 8;
	localparam int LFSR_W = 15;
	localparam int LEN_W = 16;
	localparam logic [14:0] LFSR_SEED = 15'h7fff;
	localparam logic [7:0] CONST_BYTE = 8'h55;

	typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP, GEN_DONE} pbist_gen_t;
endpackage : pbist_pkg

// ===== verif/pbist_loop_model.sv
`timescale 1ns/100ps
// Looped data path: returns each sent byte one cycle later
module pbist_loop_model (
	input wire logic clk_sys_in,
	input wire logic [3:0] corrupt_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out
);
	logic [3:0] n_r = 4'h0;
	initial rx_data_out = 8'h00;
	initial rx_valid_out = 1'b0;
	// Inverts one byte in corrupt_in+1 (none when 0, all when 0xf); idle line flips so stale data never matches
	always @(posedge clk_sys_in) begin
		rx_valid_out <= tx_valid_in;
		if (tx_valid_in) begin
			n_r <= (n_r >= corrupt_in) ? 4'h0 : n_r + 4'h1;
			rx_data_out <= tx_data_in ^ {8{corrupt_in != 4'h0 && (n_r == 4'h0 || &corrupt_in)}};
		end else
			rx_data_out <= ~rx_data_out;
	end
endmodule : pbist_loop_model

// ===== verif/pbist_sva.sv
`timescale 1ns/100ps
// Port-level watch on the self-test block
module pbist_sva (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic tx_byte_en_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	input wire logic core_normal_power_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [7:0] tx_data_out,
	input wire logic tx_valid_out,
	input wire logic [4:0] loopback_sel_out,
	input wire logic irq_out
);
	logic [15:0] ctl_r;
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);
	// Shadow of the control word, so output checks know the mode
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			ctl_r <= 16'h0000;
		else if (reg_wr_in && reg_addr_in == pbist_pkg::OFF_CTRL)
			ctl_r <= reg_wdata_in & 16'hf01f; // Reserved bits never stick
	end
	a_lb_follow: assert property (
		reg_wr_in && reg_addr_in == pbist_pkg::OFF_CTRL |=> loopback_sel_out == $past(reg_wdata_in[4:0]))
		else $error("loopback select not as written");
	a_out_reset: assert property (
		$past(srst_in) |-> loopback_sel_out == 5'h00 && !tx_valid_out && !irq_out)
		else $error("outputs not cleared by reset");
	a_tx_cause: assert property (
		tx_valid_out |-> $past(tx_byte_en_in) && $past(ctl_r[12]))
		else $error("byte sent without enable");
	a_const_byte: assert property (
		tx_valid_out && !ctl_r[14] && !$past(ctl_r[14]) |-> tx_data_out == pbist_pkg::CONST_BYTE)
		else $error("constant packet byte wrong");
	a_ctrl_read: assert property (
		reg_rd_in && reg_addr_in == pbist_pkg::OFF_CTRL |=> reg_rdata_out == $past(ctl_r))
		else $error("control readback wrong");
	a_power_bit: assert property (
		reg_rd_in && reg_addr_in == pbist_pkg::OFF_STATUS && $stable(core_normal_power_in)
		|=> reg_rdata_out[8] == $past(core_normal_power_in))
		else $error("power status bit wrong");
	a_err_width: assert property (
		reg_rd_in && reg_addr_in == pbist_pkg::OFF_ERR_CNT |=> reg_rdata_out[15:8] == 8'h00)
		else $error("error count upper byte set");
	a_rd_once: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
		else $error("read data outside its cycle");
endmodule : pbist_sva

bind pbist_core pbist_sva u_sva (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .tx_byte_en_in(tx_byte_en_in), .rx_data_in(rx_data_in),
	.rx_valid_in(rx_valid_in), .core_normal_power_in(core_normal_power_in),
	.reg_rdata_out(reg_rdata_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
	.loopback_sel_out(loopback_sel_out), .irq_out(irq_out));

// ===== verif/prbs_packet_bist_loopback_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the packet self-test block
module prbs_packet_bist_loopback_tb;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic tx_byte_en_in = 1'b0;
	logic core_normal_power_in = 1'b1;
	logic [3:0] corrupt = 4'h0;
	logic [7:0] rx_data_in;
	logic rx_valid_in;
	logic [15:0] reg_rdata_out;
	logic [7:0] tx_data_out;
	logic tx_valid_out;
	logic [4:0] loopback_sel_out;
	logic irq_out;
	int compares = 0;
	int fail_count = 0;
	int run_len = 0;
	int last_len = 0;
	int pkts = 0;
	int tx_tot = 0;
	int rx_cnt = 0;
	int b0;
	logic [15:0] v;
	logic [15:0] fz;
	// Control word written, then value read back
	logic [15:0] rows [0:6][0:1] = '{'{16'h0001, 16'h0001}, '{16'h0002, 16'h0002},
		'{16'h0004, 16'h0004}, '{16'h0008, 16'h0008}, '{16'h0010, 16'h0010},
		'{16'h0fff, 16'h001f}, '{16'ha000, 16'ha000}};
	pbist_core #(.IPG_BYTES(8)) u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .tx_byte_en_in(tx_byte_en_in), .rx_data_in(rx_data_in),
		.rx_valid_in(rx_valid_in), .core_normal_power_in(core_normal_power_in),
		.reg_rdata_out(reg_rdata_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
		.loopback_sel_out(loopback_sel_out), .irq_out(irq_out));
	pbist_loop_model u_far (.clk_sys_in(clk_sys_in), .corrupt_in(corrupt),
		.tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .rx_data_out(rx_data_in),
		.rx_valid_out(rx_valid_in));
	initial forever #10 clk_sys_in = ~clk_sys_in;
	// Packet lengths and byte totals seen on the looped path
	always @(posedge clk_sys_in) begin
		if (tx_valid_out) begin
			run_len <= run_len + 1;
			tx_tot <= tx_tot + 1;
		end else if (run_len != 0) begin
			last_len <= run_len;
			pkts <= pkts + 1;
			run_len <= 0;
		end
		if (rx_valid_in)
			rx_cnt <= rx_cnt + 1;
	end
	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// Data is taken at the edge closing its only valid cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		@(posedge clk_sys_in);
		d = reg_rdata_out;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rc
	task automatic ctl(input logic [15:0] d, input int n);
		wr(pbist_pkg::OFF_CTRL, d);
		repeat (n) @(posedge clk_sys_in);
	endtask : ctl
	task automatic wr_irq(input logic [7:0] a, input logic [15:0] d, input logic e);
		wr(a, d);
		repeat (2) @(posedge clk_sys_in);
		chk({15'h0000, irq_out}, {15'h0000, e});
	endtask : wr_irq
	// Hang guard
	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		tx_byte_en_in <= 1'b1;
		rc(pbist_pkg::OFF_CTRL, 16'h0000);
		rc(pbist_pkg::OFF_BYTE_CNT, 16'h0000);
		rc(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		rc(pbist_pkg::OFF_STATUS, 16'h0100);
		rc(8'h20, 16'h0000);
		core_normal_power_in <= 1'b0;
		rc(pbist_pkg::OFF_STATUS, 16'h0000);
		core_normal_power_in <= 1'b1;
		foreach (rows[i]) begin
			wr(pbist_pkg::OFF_CTRL, rows[i][0]);
			rc(pbist_pkg::OFF_CTRL, rows[i][1]);
			chk({11'h000, loopback_sel_out}, {11'h000, rows[i][1][4:0]});
		end
		// One constant packet, then the done interrupt through its mask
		ctl(16'h3000, 0);
		rc(pbist_pkg::OFF_STATUS, 16'h0300);
		repeat (200) @(posedge clk_sys_in);
		chk(16'(tx_tot), 16'h0040);
		chk(16'(last_len), 16'h0040);
		rc(pbist_pkg::OFF_STATUS, 16'h0100);
		rc(pbist_pkg::OFF_BYTE_CNT, 16'h0000);
		rc(pbist_pkg::OFF_IRQ_STAT, 16'h0004);
		chk({15'h0000, irq_out}, 16'h0000);
		wr_irq(pbist_pkg::OFF_IRQ_MASK, 16'h0004, 1'b1);
		wr_irq(pbist_pkg::OFF_IRQ_STAT, 16'h0004, 1'b0);
		// Long PRBS packets counted by the checker
		ctl(16'h4000, 0);
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0002);
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		b0 = rx_cnt;
		ctl(16'h5000, 3200);
		chk(16'(last_len), 16'h05ee);
		chk(16'(pkts > 2), 16'h0001);
		rc(pbist_pkg::OFF_STATUS, 16'h0b00);
		ctl(16'h4000, 8);
		rc(pbist_pkg::OFF_BYTE_CNT, 16'(rx_cnt - b0));
		rc(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		// Lock freezes the readable count while traffic goes on
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0001);
		fz = 16'(rx_cnt - b0);
		ctl(16'h7000, 300);
		chk(16'(last_len), 16'h0040);
		ctl(16'h4000, 8);
		rc(pbist_pkg::OFF_BYTE_CNT, fz);
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		rc(pbist_pkg::OFF_BYTE_CNT, 16'(rx_cnt - b0));
		// Continuous mode: error count passes its maximum and wraps
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0002);
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		corrupt <= 4'h7;
		ctl(16'hd000, 3000);
		rd(pbist_pkg::OFF_IRQ_STAT, v);
		chk(v & 16'h0002, 16'h0002);
		wr(pbist_pkg::OFF_IRQ_STAT, 16'h0007);
		// Burst of bad bytes breaks the lock
		corrupt <= 4'hf;
		repeat (40) @(posedge clk_sys_in);
		corrupt <= 4'h0;
		ctl(16'h4000, 8);
		rd(pbist_pkg::OFF_STATUS, v);
		chk(v & 16'h0400, 16'h0400);
		wr_irq(pbist_pkg::OFF_IRQ_MASK, 16'h0001, 1'b1);
		wr_irq(pbist_pkg::OFF_IRQ_STAT, 16'h0001, 1'b0);
		// Single mode: counting halts at the error maximum
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0002);
		wr(pbist_pkg::OFF_ERR_CNT, 16'h0000);
		b0 = rx_cnt;
		corrupt <= 4'h7;
		ctl(16'h5000, 3000);
		corrupt <= 4'h0;
		ctl(16'h4000, 8);
		rc(pbist_pkg::OFF_ERR_CNT, 16'h00ff);
		rd(pbist_pkg::OFF_BYTE_CNT, v);
		chk(16'(v < 16'(rx_cnt - b0)), 16'h0001);
		// Reset in mid-run
		ctl(16'h5010, 20);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rc(pbist_pkg::OFF_CTRL, 16'h0000);
		finish_test();
	end
endmodule : prbs_packet_bist_loopback_tb
